// ---- hw/axi_parity_guard.sv ----
`timescale 1ns/1ps
// ****************************************
// parity check signals for a write/read address master
// ****************************************
// Behaviour
// - checks generated and sampled on one clock
// - check correct whenever its enable holds
// - one odd bit over write control group
// - one odd bit over read control group
// - one odd bit over write coherency group
// - check plus covered bits have odd count
// - check bit n covers byte n
// - handshake check is inverted signal
// - absent signals count low, empty checks omitted
module axi_parity_guard #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 64
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // write address, master side
  input wire logic aw_valid,
  input wire logic [ADDR_W-1:0] aw_addr,
  input wire logic [2:0] aw_size,
  input wire logic [1:0] aw_burst,
  input wire logic aw_lock,
  input wire logic [2:0] aw_prot,
  input wire logic [1:0] aw_domain,
  input wire logic [3:0] aw_snoop,
  input wire logic aw_unique,
  input wire logic [1:0] aw_bar,
  // read address, master side
  input wire logic ar_valid,
  input wire logic [2:0] ar_size,
  input wire logic [1:0] ar_burst,
  input wire logic ar_lock,
  input wire logic [2:0] ar_prot,
  // read data received from the slave, with its checks
  input wire logic r_valid,
  input wire logic [DATA_W-1:0] r_data,
  input wire logic [(DATA_W+7)/8-1:0] r_data_chk,
  input wire logic r_valid_chk,
  // registered outgoing checks
  output logic aw_valid_chk,
  output logic [(ADDR_W+7)/8-1:0] aw_addr_chk,
  output logic aw_ctl0_chk,
  output logic aw_ctl2_chk,
  output logic ar_valid_chk,
  output logic ar_ctl0_chk,
  // registered error flags from the receive side
  output logic r_data_err,
  output logic r_valid_err
);
  localparam int AB = (ADDR_W + 7) / 8;
  localparam int DB = (DATA_W + 7) / 8;

  // ****************************************
  // parity generators
  // ****************************************
  // note: registered outputs shift the check one cycle after the
  // payload; the system is expected to register payload alongside
  logic [AB-1:0] addr_par;
  logic [0:0] ctl0_w_par;
  logic [0:0] ctl2_w_par;
  logic [0:0] ctl0_r_par;
  logic [DB-1:0] rdata_par;

  // a short top lane counts its missing bits low
  odd_parity_gen #(
    .W(ADDR_W),
    .LANE_W(parity_chk_pkg::BYTE_W)
  ) u_addr (
    .payload(aw_addr),
    .chk(addr_par)
  );
  // write control group in one bit
  // nine bits in one lane: a byte lane would split the group in two
  odd_parity_gen #(
    .W(parity_chk_pkg::CTL0_W),
    .LANE_W(parity_chk_pkg::CTL0_W)
  ) u_wctl0 (
    .payload({aw_size, aw_burst, aw_lock, aw_prot}),
    .chk(ctl0_w_par)
  );
  odd_parity_gen #(
    .W(parity_chk_pkg::CTL2_W),
    .LANE_W(parity_chk_pkg::CTL2_W)
  ) u_wctl2 (
    .payload({aw_domain, aw_snoop, aw_unique, aw_bar}),
    .chk(ctl2_w_par)
  );
  // read control group in one bit
  odd_parity_gen #(
    .W(parity_chk_pkg::CTL0_W),
    .LANE_W(parity_chk_pkg::CTL0_W)
  ) u_rctl0 (
    .payload({ar_size, ar_burst, ar_lock, ar_prot}),
    .chk(ctl0_r_par)
  );
  // recompute on received data
  odd_parity_gen #(
    .W(DATA_W),
    .LANE_W(parity_chk_pkg::BYTE_W)
  ) u_rdata (
    .payload(r_data),
    .chk(rdata_par)
  );

  // ****************************************
  // next values
  // ****************************************
  logic next_aw_valid_chk;
  logic [AB-1:0] next_aw_addr_chk;
  logic next_aw_ctl0_chk;
  logic next_aw_ctl2_chk;
  logic next_ar_valid_chk;
  logic next_ar_ctl0_chk;
  logic next_r_data_err;
  logic next_r_valid_err;

  // combinational next state
  always_comb
  begin
    next_aw_valid_chk = ~aw_valid;
    next_ar_valid_chk = ~ar_valid;
    // payload checks driven every cycle, valid-qualified use
    next_aw_addr_chk = addr_par;
    next_aw_ctl0_chk = ctl0_w_par[0];
    next_aw_ctl2_chk = ctl2_w_par[0];
    next_ar_ctl0_chk = ctl0_r_par[0];
    // data compare only while r_valid holds, valid check compared every cycle; flags are per cycle
    next_r_data_err = r_valid && (r_data_chk != rdata_par);
    next_r_valid_err = (r_valid_chk == r_valid);
  end

  // ****************************************
  // output registers
  // ****************************************
  // reset leaves handshake checks high, as for an idle valid
  // all state on sys_clk
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      aw_valid_chk <= ~parity_chk_pkg::RST_CHK;
      aw_addr_chk <= {AB{parity_chk_pkg::RST_CHK}};
      aw_ctl0_chk <= parity_chk_pkg::RST_CHK;
      aw_ctl2_chk <= parity_chk_pkg::RST_CHK;
      ar_valid_chk <= ~parity_chk_pkg::RST_CHK;
      ar_ctl0_chk <= parity_chk_pkg::RST_CHK;
      r_data_err <= parity_chk_pkg::RST_ERR;
      r_valid_err <= parity_chk_pkg::RST_ERR;
    end
    else
    begin
      aw_valid_chk <= next_aw_valid_chk;
      aw_addr_chk <= next_aw_addr_chk;
      aw_ctl0_chk <= next_aw_ctl0_chk;
      aw_ctl2_chk <= next_aw_ctl2_chk;
      ar_valid_chk <= next_ar_valid_chk;
      ar_ctl0_chk <= next_ar_ctl0_chk;
      r_data_err <= next_r_data_err;
      r_valid_err <= next_r_valid_err;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  // write valid inverted
  chk_valid_invert: assert property (
    @(posedge sys_clk) disable iff (srst) !$past(srst) |-> aw_valid_chk == !$past(aw_valid))
    else $error("aw valid check not inverted");
  chk_ctl0_odd: assert property (
    @(posedge sys_clk) disable iff (srst)
    $past(aw_valid) && !$past(srst) |->
      ^{aw_ctl0_chk, $past(aw_size), $past(aw_burst), $past(aw_lock), $past(aw_prot)})
    else $error("write control parity even");
  chk_ctl2_odd: assert property (
    @(posedge sys_clk) disable iff (srst)
    $past(aw_valid) && !$past(srst) |->
      ^{aw_ctl2_chk, $past(aw_domain), $past(aw_snoop), $past(aw_unique), $past(aw_bar)})
    else $error("coherency parity even");
  chk_rctl0_odd: assert property (
    @(posedge sys_clk) disable iff (srst)
    $past(ar_valid) && !$past(srst) |->
      ^{ar_ctl0_chk, $past(ar_size), $past(ar_burst), $past(ar_lock), $past(ar_prot)})
    else $error("read control parity even");
  chk_addr_byte0: assert property (
    @(posedge sys_clk) disable iff (srst)
    $past(aw_valid) && !$past(srst) |-> ^{aw_addr_chk[0], $past(aw_addr[7:0])})
    else $error("address byte zero parity even");
  chk_addr_top: assert property (
    @(posedge sys_clk) disable iff (srst)
    $past(aw_valid) && !$past(srst) |->
      ^{aw_addr_chk[AB-1], $past(aw_addr[ADDR_W-1:(AB-1)*parity_chk_pkg::BYTE_W])})
    else $error("address top lane parity even");
  chk_rvalid_inv: assert property (
    @(posedge sys_clk) disable iff (srst) !$past(srst) |-> ar_valid_chk != $past(ar_valid))
    else $error("ar valid check not inverted");

  // ****************************************
  // receive side checks
  // ****************************************
  // bad lane 0 flagged
  chk_rdata_err: assert property (
    @(posedge sys_clk) disable iff (srst)
    r_valid && ^{r_data_chk[0], r_data[7:0]} == 1'b0 |=> r_data_err)
    else $error("read data error not flagged");
  chk_rdata_quiet: assert property (
    @(posedge sys_clk) disable iff (srst) !r_valid |=> !r_data_err)
    else $error("error flagged without valid");
  chk_rverr_flag: assert property (
    @(posedge sys_clk) disable iff (srst) r_valid_chk == r_valid |=> r_valid_err)
    else $error("valid check error not flagged");
  chk_rverr_quiet: assert property (
    @(posedge sys_clk) disable iff (srst) r_valid_chk != r_valid |=> !r_valid_err)
    else $error("valid check error without cause");
endmodule : axi_parity_guard

// ---- hw/odd_parity_gen.sv ----
`timescale 1ns/1ps
// odd parity per lane, top lane takes the leftover bits
module odd_parity_gen #(
  parameter int W = 8,
  // bits per lane; a control group rides in one lane as wide as itself
  parameter int LANE_W = parity_chk_pkg::BYTE_W
) (
  // payload in
  input wire logic [W-1:0] payload,
  // one check bit per lane
  output logic [(W+LANE_W-1)/LANE_W-1:0] chk
);
  // lane count, rounded up so a partial top lane still gets a bit
  localparam int N = (W + LANE_W - 1) / LANE_W;

  // ****************************************
  // lane parity
  // ****************************************
  // lane n covers bits LANE_W*n+LANE_W-1..LANE_W*n
  always_comb
  begin
    chk = '0;
    for (int n = 0; n < N; n++)
    begin
      chk[n] = 1'b1;
      for (int b = 0; b < LANE_W; b++)
      begin
        // bits past the payload count as low
        if (n * LANE_W + b < W)
        begin
          chk[n] = chk[n] ^ payload[n * LANE_W + b];
        end
      end
    end
  end
endmodule : odd_parity_gen

// ---- hw/parity_chk_pkg.sv ----
package parity_chk_pkg;
  // ****************************************
  // widths of the covered field groups
  // ****************************************
  // size 3, burst 2, lock 1, prot 3 -> nine bits
  localparam int CTL0_W = 9;
  // domain 2, snoop 4, unique 1, barrier 2 -> nine bits
  localparam int CTL2_W = 9;
  // bits covered by one check bit of a wide check signal
  localparam int BYTE_W = 8;
  // reset values of the registered outputs; handshake checks take the inverse of RST_CHK
  localparam logic RST_CHK = 1'h0;
  localparam logic RST_ERR = 1'h0;
endpackage : parity_chk_pkg

// ---- sim/axi_parity_guard_tb_top.sv ----
`timescale 1ns/1ps
module axi_parity_guard_tb_top;
  localparam int AW = 12; // top address lane holds only four bits
  localparam int DW = 16;
  localparam logic [11:0] PAT [4] = '{12'h000, 12'hfff, 12'h801, 12'h3c5};
  // rows of send, corrupt data lanes, corrupt valid check
  localparam logic [2:0] ROW [5] = '{3'h4, 3'h6, 3'h2, 3'h5, 3'h1};
  int fail_count = 0;
  int tests_run = 0;
  logic sys_clk = 1'h0;
  logic srst = 1'h1;
  logic aw_valid = 1'h0, ar_valid = 1'h0, send = 1'h0, bad_data = 1'h0, bad_valid = 1'h0;
  logic [AW-1:0] aw_addr = 12'h000;
  logic [8:0] c0 = 9'h000, c2 = 9'h000, r0 = 9'h000; // control groups
  logic [DW-1:0] data = 16'h0000, r_data;
  logic r_valid, r_valid_chk, r_data_err, r_valid_err;
  logic [1:0] r_data_chk, aw_addr_chk;
  logic aw_valid_chk, aw_ctl0_chk, aw_ctl2_chk, ar_valid_chk, ar_ctl0_chk;
  axi_parity_guard #(.ADDR_W(AW), .DATA_W(DW)) axi_parity_guard_i (
    .sys_clk, .srst, .aw_valid, .aw_addr, .aw_size(c0[8:6]), .aw_burst(c0[5:4]),
    .aw_lock(c0[3]), .aw_prot(c0[2:0]), .aw_domain(c2[8:7]), .aw_snoop(c2[6:3]),
    .aw_unique(c2[2]), .aw_bar(c2[1:0]), .ar_valid, .ar_size(r0[8:6]),
    .ar_burst(r0[5:4]), .ar_lock(r0[3]), .ar_prot(r0[2:0]), .r_valid, .r_data,
    .r_data_chk, .r_valid_chk, .aw_valid_chk, .aw_addr_chk, .aw_ctl0_chk,
    .aw_ctl2_chk, .ar_valid_chk, .ar_ctl0_chk, .r_data_err, .r_valid_err
  );
  rd_src #(.DATA_W(DW)) rd_src_i (
    .sys_clk, .send, .data, .bad_data, .bad_valid, .r_valid, .r_data, .r_data_chk,
    .r_valid_chk
  );
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask : check
  task conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // reset holds the valid checks, address check and data error at their idle values
  task reset_values();
    check("aw_valid_chk", aw_valid_chk, 8'h01);
    check("ar_valid_chk", ar_valid_chk, 8'h01);
    check("aw_addr_chk", aw_addr_chk, 8'h00);
    check("r_data_err", r_data_err, 8'h00);
  endtask : reset_values
  // every group changes each cycle, back to back
  task addr_groups();
    for (int i = 0; i < 4; i++)
    begin
      aw_valid = i[0];
      ar_valid = ~i[0];
      aw_addr = PAT[i];
      c0 = PAT[i][8:0];
      c2 = ~PAT[i][9:1];
      r0 = PAT[i][11:3];
      @(posedge sys_clk);
      #1;
      check("aw_valid_chk", aw_valid_chk, {7'h00, ~aw_valid});
      check("ar_valid_chk", ar_valid_chk, {7'h00, ~ar_valid});
      check("aw_addr_chk", aw_addr_chk, {~^aw_addr[11:8], ~^aw_addr[7:0]});
      check("aw_addr_top", aw_addr_chk[1], {7'h00, ~^{4'h0, aw_addr[11:8]}});
      check("aw_ctl0_chk", aw_ctl0_chk, 8'(~^c0));
      check("aw_ctl2_chk", aw_ctl2_chk, 8'(~^c2));
      check("ar_ctl0_chk", ar_ctl0_chk, 8'(~^r0));
    end
  endtask : addr_groups
  // bad lanes flagged only with valid; valid check judged always
  task read_errors();
    for (int i = 0; i < 5; i++)
    begin
      {send, bad_data, bad_valid} = ROW[i];
      data = 16'h5a3c ^ 16'(i);
      repeat (2) @(posedge sys_clk);
      #1;
      check("r_data_err", r_data_err, {7'h00, send & bad_data});
      check("r_valid_err", r_valid_err, {7'h00, bad_valid});
    end
  endtask : read_errors
  // reset in mid-run wins over a live request
  task mid_reset();
    srst = 1'h1;
    aw_valid = 1'h1;
    @(posedge sys_clk);
    #1;
    reset_values();
    srst = 1'h0;
  endtask : mid_reset
  initial
  begin
    repeat (16) @(posedge sys_clk);
    #1;
    reset_values();
    srst = 1'h0;
    addr_groups();
    read_errors();
    mid_reset();
    addr_groups();
    conclude();
  end
  // the run needs well under a hundred cycles
  initial
  begin
    #20000;
    fail_count++;
    conclude();
  end
endmodule : axi_parity_guard_tb_top

// ---- sim/rd_src.sv ----
`timescale 1ns/1ps
// stands in for the slave returning read data with its checks
module rd_src #(
  parameter int DATA_W = 16
) (
  // clock and orders from the bench
  input wire logic sys_clk,
  input wire logic send,
  input wire logic [DATA_W-1:0] data,
  input wire logic bad_data,
  input wire logic bad_valid,
  // read data channel toward the guard
  output logic r_valid,
  output logic [DATA_W-1:0] r_data,
  output logic [DATA_W/8-1:0] r_data_chk,
  output logic r_valid_chk
);
  initial r_data = '0;
  // drives after the edge; idle data toggles so a stale value never looks held
  always @(posedge sys_clk)
  begin
    #2;
    r_valid <= send;
    r_data <= send ? data : ~r_data;
    // one check bit per byte lane
    // odd count per lane, flipped only on order
    for (int n = 0; n < DATA_W/8; n++)
      r_data_chk[n] <= ~^data[8*n+:8] ^ bad_data;
    r_valid_chk <= ~send ^ bad_valid;
  end
endmodule : rd_src
